/* pfsof_params.svh */
// Constants of the probe fault supervisor
`ifndef PFSOF_PARAMS_SVH
`define PFSOF_PARAMS_SVH
`define PFSOF_CODE_W        5
`define PFSOF_NCODES        32
`define PFSOF_C_PROG        5'h01
`define PFSOF_C_PARAM       5'h02
`define PFSOF_C_SUPPLY      5'h05
`define PFSOF_C_RAIL30      5'h06
`define PFSOF_C_RXLOW       5'h07
`define PFSOF_C_RAIL8       5'h08
`define PFSOF_C_RXCUT       5'h09
`define PFSOF_C_RANGE       5'h0D
`define PFSOF_C_HEATER      5'h0E
`define PFSOF_C_SRCTEMP     5'h0F
`define PFSOF_C_SLOPE       5'h10
`define PFSOF_C_RAIL25      5'h11
`define PFSOF_C_RAIL17      5'h12
`define PFSOF_C_SRCCUR      5'h13
`define PFSOF_C_SIGLOW      5'h15
`define PFSOF_C_CUTWARN     5'h17
`define PFSOF_C_RESTART     5'h18
`define PFSOF_C_ADJ         5'h1B
`define PFSOF_C_CALSOON     5'h1D
`define PFSOF_C_CALEXP      5'h1E
`define PFSOF_CRIT_MASK     32'h0000_0006
`define PFSOF_ERR_MASK      32'h000F_E3E0
`define PFSOF_WARN_MASK     32'h01A0_0000
`define PFSOF_STAT_MASK     32'h6800_0000
// Error levels in microamps or millivolts
`define PFSOF_LVL_0_20MA    16'h59D8
`define PFSOF_LVL_4_20MA    16'h07D0
`define PFSOF_LVL_VOLT      16'h0000
`endif

/* pfsof_pkg.sv */
// Types of the probe fault supervisor
package pfsof_pkg;
   typedef enum logic [1:0] {
      PFSOF_OUT_0_20MA,
      PFSOF_OUT_4_20MA,
      PFSOF_OUT_0_5V,
      PFSOF_OUT_0_10V
   } pfsof_otype_e;
   typedef enum logic [1:0] {
      PFSOF_SEV_NONE,
      PFSOF_SEV_STAT,
      PFSOF_SEV_WARN,
      PFSOF_SEV_ERR
   } pfsof_sev_e;
endpackage

/* pfsof_channel.sv */
// One analog channel with error-level fallback
`timescale 1ns/1ps
`include "pfsof_params.svh"
module pfsof_channel #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_ce,
   // Control
   input  wire logic                  i_meas_err,
   input  wire pfsof_pkg::pfsof_otype_e i_otype,
   input  wire logic [W-1:0]          i_value,
   input  wire logic [W-1:0]          i_lo,
   input  wire logic [W-1:0]          i_hi,
   // Output
   output logic [W-1:0]               o_level,
   output logic                       o_fallback
);
   logic [W-1:0] level_ff;
   logic         fb_ff;
   logic [W-1:0] err_level;
   logic         out_of_range;
   logic         nxt_fb;
   logic [W-1:0] nxt_level;

   ////////////////////////////////////////////////////////////////////
   // RULE10: level by type
   assign err_level = (i_otype == pfsof_pkg::PFSOF_OUT_0_20MA) ?
                      W'(`PFSOF_LVL_0_20MA) :
                      (i_otype == pfsof_pkg::PFSOF_OUT_4_20MA) ?
                      W'(`PFSOF_LVL_4_20MA) : W'(`PFSOF_LVL_VOLT);
   // RULE9: outside scaled range
   assign out_of_range = (i_value < i_lo) || (i_value > i_hi);
   // RULE11: recovers when cause gone
   assign nxt_fb    = i_meas_err || out_of_range;
   assign nxt_level = nxt_fb ? err_level : i_value;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         level_ff <= W'(`PFSOF_LVL_VOLT);
         fb_ff    <= 1'b1;
      end else if (i_ce) begin
         level_ff <= nxt_level;
         fb_ff    <= nxt_fb;
      end
   end

   assign o_level    = level_ff;
   assign o_fallback = fb_ff;

   ////////////////////////////////////////////////////////////////////
   range_fallback_a: assert property ( // RULE9
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && out_of_range |=> o_fallback && o_level == $past(err_level))
      else $error("out of range value not replaced");
   normal_pass_a: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && !nxt_fb |=> !o_fallback && o_level == $past(i_value))
      else $error("normal value not passed");
   // Reset parks the level at 0 V, so the first edge is skipped
   lvl_4ma_a: assert property ( // RULE10
      @(posedge i_clk) disable iff (!i_rstn)
      o_fallback && i_otype == pfsof_pkg::PFSOF_OUT_4_20MA &&
      $stable(i_otype) && $past(i_ce) && $past(i_rstn)
      |-> o_level == W'(`PFSOF_LVL_4_20MA))
      else $error("wrong 4-20 mA error level");
endmodule

/* pfsof_top.sv */
// Probe fault and status supervisor with analog fallback
// Function
// RULE1: codes 1,2 flag corrupted stores critical
// RULE2: error class blanks result, forces outputs
// RULE3: codes 5,6,8,17,18 flag rail faults
// RULE4: codes 7,9,14,15,16,19 flag sensing faults
// RULE5: code 13 follows concentration over range
// RULE6: warnings 21,23 keep normal output
// RULE7: watchdog restart sets warning 24
// RULE8: status 27 adjust, 29,30 calibration
// RULE9: far out of range forces error level
// RULE10: error level chosen by output type
// RULE11: normal output returns when cause clears
// RULE12: one independent flag per code
`timescale 1ns/1ps
`include "pfsof_params.svh"
module pfsof_top #(
   parameter int NCH = 2,
   parameter int W   = 16
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_ce,
   // Critical condition levels
   input  wire logic                  i_prog_crc_bad,
   input  wire logic                  i_param_crc_bad,
   // Error condition levels
   input  wire logic                  i_supply_low,
   input  wire logic                  i_rail30_low,
   input  wire logic                  i_rail8_low,
   input  wire logic                  i_rail25_bad,
   input  wire logic                  i_rail17_bad,
   input  wire logic                  i_rx_low,
   input  wire logic                  i_rx_cut,
   input  wire logic                  i_conc_over,
   input  wire logic                  i_heater_bad,
   input  wire logic                  i_infrared_source_temp_bad,
   input  wire logic                  i_interferometer_receiver_slope_bad,
   input  wire logic                  i_infrared_source_cur_low,
   // Warning and status levels
   input  wire logic                  i_sig_low_warn,
   input  wire logic                  i_cut_warn,
   input  wire logic                  i_wdog_restart,
   input  wire logic                  i_restart_ack,
   input  wire logic                  i_adjust_mode,
   input  wire logic                  i_cal_soon,
   input  wire logic                  i_cal_expired,
   // Measurement
   input  wire logic [W-1:0]          i_meas,
   input  wire logic                  i_meas_vld,
   input  wire pfsof_pkg::pfsof_otype_e i_otype [NCH],
   input  wire logic [W-1:0]          i_ch_value [NCH],
   input  wire logic [W-1:0]          i_ch_lo [NCH],
   input  wire logic [W-1:0]          i_ch_hi [NCH],
   // Status out
   output logic [`PFSOF_NCODES-1:0]   o_active,
   output pfsof_pkg::pfsof_sev_e      o_worst,
   output logic                       o_critical,
   output logic                       o_error,
   // Results out
   output logic [W-1:0]               o_meas,
   output logic                       o_meas_vld,
   output logic [W-1:0]               o_ch_level [NCH],
   output logic                       o_ch_fallback [NCH]
);
   logic [`PFSOF_NCODES-1:0] active_ff;
   logic [`PFSOF_NCODES-1:0] nxt_active;
   logic [`PFSOF_NCODES-1:0] cond;
   logic [W-1:0]             meas_ff;
   logic                     vld_ff;
   logic                     err_any;
   logic                     crit_any;

   function automatic logic [`PFSOF_NCODES-1:0] bit_of(
      input logic [`PFSOF_CODE_W-1:0] code);
      bit_of = `PFSOF_NCODES'(1) << code;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // RULE1: critical store codes
   // RULE3: rail fault codes
   // RULE4: sensing path codes
   // RULE5: range code tracks input
   // RULE6: warning codes
   // RULE8: status codes
   assign cond =
      ({`PFSOF_NCODES{i_prog_crc_bad}}  & bit_of(`PFSOF_C_PROG))    |
      ({`PFSOF_NCODES{i_param_crc_bad}} & bit_of(`PFSOF_C_PARAM))   |
      ({`PFSOF_NCODES{i_supply_low}}    & bit_of(`PFSOF_C_SUPPLY))  |
      ({`PFSOF_NCODES{i_rail30_low}}    & bit_of(`PFSOF_C_RAIL30))  |
      ({`PFSOF_NCODES{i_rx_low}}        & bit_of(`PFSOF_C_RXLOW))   |
      ({`PFSOF_NCODES{i_rail8_low}}     & bit_of(`PFSOF_C_RAIL8))   |
      ({`PFSOF_NCODES{i_rx_cut}}        & bit_of(`PFSOF_C_RXCUT))   |
      ({`PFSOF_NCODES{i_conc_over}}     & bit_of(`PFSOF_C_RANGE))   |
      ({`PFSOF_NCODES{i_heater_bad}}    & bit_of(`PFSOF_C_HEATER))  |
      ({`PFSOF_NCODES{i_infrared_source_temp_bad}}
                                        & bit_of(`PFSOF_C_SRCTEMP)) |
      ({`PFSOF_NCODES{i_interferometer_receiver_slope_bad}}
                                        & bit_of(`PFSOF_C_SLOPE))   |
      ({`PFSOF_NCODES{i_rail25_bad}}    & bit_of(`PFSOF_C_RAIL25))  |
      ({`PFSOF_NCODES{i_rail17_bad}}    & bit_of(`PFSOF_C_RAIL17))  |
      ({`PFSOF_NCODES{i_infrared_source_cur_low}}
                                        & bit_of(`PFSOF_C_SRCCUR))  |
      ({`PFSOF_NCODES{i_sig_low_warn}}  & bit_of(`PFSOF_C_SIGLOW))  |
      ({`PFSOF_NCODES{i_cut_warn}}      & bit_of(`PFSOF_C_CUTWARN)) |
      ({`PFSOF_NCODES{i_adjust_mode}}   & bit_of(`PFSOF_C_ADJ))     |
      ({`PFSOF_NCODES{i_cal_soon}}      & bit_of(`PFSOF_C_CALSOON)) |
      ({`PFSOF_NCODES{i_cal_expired}}   & bit_of(`PFSOF_C_CALEXP));

   // RULE7: sticky restart, set beats ack
   wire restart_keep = active_ff[`PFSOF_C_RESTART] && !i_restart_ack;
   wire restart_nxt  = i_wdog_restart || restart_keep;
   // RULE12: independent flag per code
   assign nxt_active = cond |
      ({`PFSOF_NCODES{restart_nxt}} & bit_of(`PFSOF_C_RESTART));

   // RULE2: any error class code
   assign err_any  = |(active_ff & `PFSOF_ERR_MASK);
   assign crit_any = |(active_ff & `PFSOF_CRIT_MASK);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         active_ff <= `PFSOF_NCODES'(0);
      end else if (i_ce) begin
         active_ff <= nxt_active;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // RULE2: measurement suppressed on error
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meas_ff <= W'(0);
         vld_ff  <= 1'b0;
      end else if (i_ce) begin
         meas_ff <= err_any ? W'(0) : i_meas;
         vld_ff  <= i_meas_vld && !err_any;
      end
   end

   assign o_active   = active_ff;
   assign o_critical = crit_any;
   assign o_error    = err_any;
   assign o_meas     = meas_ff;
   assign o_meas_vld = vld_ff;
   assign o_worst    = (crit_any || err_any) ? pfsof_pkg::PFSOF_SEV_ERR :
      |(active_ff & `PFSOF_WARN_MASK) ? pfsof_pkg::PFSOF_SEV_WARN :
      |(active_ff & `PFSOF_STAT_MASK) ? pfsof_pkg::PFSOF_SEV_STAT :
      pfsof_pkg::PFSOF_SEV_NONE;

   ////////////////////////////////////////////////////////////////////
   // RULE2: every channel to error level
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         pfsof_channel #(.W(W)) u_ch (
            .i_clk      (i_clk),
            .i_rstn     (i_rstn),
            .i_ce       (i_ce),
            .i_meas_err (err_any),
            .i_otype    (i_otype[g]),
            .i_value    (i_ch_value[g]),
            .i_lo       (i_ch_lo[g]),
            .i_hi       (i_ch_hi[g]),
            .o_level    (o_ch_level[g]),
            .o_fallback (o_ch_fallback[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   crit_code_a: assert property ( // RULE1
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_param_crc_bad |=> o_active[2] && o_critical)
      else $error("parameter store code 2 missing");
   crit_worst_a: assert property ( // RULE1
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_prog_crc_bad
      |=> o_active[1] && o_worst == pfsof_pkg::PFSOF_SEV_ERR)
      else $error("program store code 1 missing");
   err_blank_a: assert property ( // RULE2
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && err_any |=> !o_meas_vld && o_ch_fallback[0])
      else $error("result not suppressed on error");
   meas_zero_a: assert property ( // RULE2
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && err_any |=> o_meas == W'(0))
      else $error("blanked result not zero");
   rail_code_a: assert property ( // RULE3
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_rail17_bad |=> o_active[18] && o_error)
      else $error("rail code 18 missing");
   sense_code_a: assert property ( // RULE4
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_infrared_source_cur_low |=> o_active[19])
      else $error("source current code 19 missing");
   cut_code_a: assert property ( // RULE4
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_rx_cut |=> o_active[9] && o_error)
      else $error("signal cut code 9 missing");
   range_clear_a: assert property ( // RULE5
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && !i_conc_over |=> !o_active[13])
      else $error("code 13 not cleared");
   // Flags of the cycle before still blank the result
   warn_only_a: assert property ( // RULE6
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && nxt_active == bit_of(`PFSOF_C_CUTWARN) && i_meas_vld &&
      !err_any |=> o_active[23] && o_meas_vld && !o_error)
      else $error("warning blocked output");
   restart_hold_a: assert property ( // RULE7
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_wdog_restart ##1 (i_ce && !i_restart_ack)[*2]
      |=> o_active[24])
      else $error("restart warning lost");
   restart_clear_a: assert property ( // RULE7
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_restart_ack && !i_wdog_restart |=> !o_active[24])
      else $error("restart warning not cleared");
   cal_code_a: assert property ( // RULE8
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce && i_cal_expired && i_adjust_mode
      |=> o_active[30] && o_active[27])
      else $error("status code missing");
   multi_flag_a: assert property ( // RULE12
      @(posedge i_clk) disable iff (!i_rstn)
      i_ce |=> o_active == $past(nxt_active))
      else $error("flag set lost");
   c_err: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_error ##1 !o_error);
   c_multi: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_error && o_active[21] && o_active[27]);
   c_restart: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_wdog_restart ##3 i_restart_ack);
   c_range: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_ch_fallback[1] && !o_error);
   c_warn: cover property (@(posedge i_clk) disable iff (!i_rstn)
      o_active[23] && o_meas_vld);
endmodule

/* pfsof_loop_rdr.sv */
// Loop meter model that watches one analog channel for its error level
`timescale 1ns/1ps
`include "pfsof_params.svh"
module pfsof_loop_rdr (
   // Clock
   input  wire logic                    i_clk,
   // Loop
   input  wire logic [15:0]             i_level,
   input  wire pfsof_pkg::pfsof_otype_e i_otype,
   // Verdict
   output logic                         o_alarm
);
   logic alarm_ff;
   logic nxt_alarm;
   // Meter sees only the loop, so 0 V is ambiguous with a zero reading
   assign nxt_alarm = (i_otype == pfsof_pkg::PFSOF_OUT_0_20MA)
                      ? (i_level > 16'h4E20)
                      : (i_otype == pfsof_pkg::PFSOF_OUT_4_20MA)
                      ? (i_level < 16'h0FA0) : (i_level == 16'h0000);
   always_ff @(posedge i_clk) begin
      alarm_ff <= nxt_alarm;
   end
   assign o_alarm = alarm_ff;
endmodule

/* test_probe_fault_status_and_output_fallback.sv */
// Self-checking bench of the probe fault supervisor
`timescale 1ns/1ps
`include "pfsof_params.svh"
module test_probe_fault_status_and_output_fallback;
   logic i_clk = 0, i_rstn = 0, i_ce = 1, ack = 0, meas_vld = 0;
   logic [31:0] cond = 0, r, a0;
   logic [15:0] meas = 0, ch_val [2], ch_lo [2], ch_hi [2], lvl [2], o_m;
   pfsof_pkg::pfsof_otype_e otype [2];
   pfsof_pkg::pfsof_sev_e   worst;
   logic [31:0] act;
   logic crit, err, o_mv, exp24, rdr_alarm, fb [2];
   int err_count = 0, checks_done = 0;
   integer seed = 32'h2fdf;
   always #5 i_clk = ~i_clk;
   pfsof_top #(.NCH(2), .W(16)) u_pfsof_top (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_prog_crc_bad(cond[1]), .i_param_crc_bad(cond[2]),
      .i_supply_low(cond[5]), .i_rail30_low(cond[6]), .i_rx_low(cond[7]),
      .i_rail8_low(cond[8]), .i_rx_cut(cond[9]), .i_conc_over(cond[13]),
      .i_heater_bad(cond[14]), .i_infrared_source_temp_bad(cond[15]),
      .i_interferometer_receiver_slope_bad(cond[16]),
      .i_rail25_bad(cond[17]), .i_rail17_bad(cond[18]),
      .i_infrared_source_cur_low(cond[19]), .i_sig_low_warn(cond[21]),
      .i_cut_warn(cond[23]), .i_wdog_restart(cond[24]),
      .i_restart_ack(ack), .i_adjust_mode(cond[27]),
      .i_cal_soon(cond[29]), .i_cal_expired(cond[30]), .i_meas(meas),
      .i_meas_vld(meas_vld), .i_otype(otype), .i_ch_value(ch_val),
      .i_ch_lo(ch_lo), .i_ch_hi(ch_hi), .o_active(act), .o_worst(worst),
      .o_critical(crit), .o_error(err), .o_meas(o_m), .o_meas_vld(o_mv),
      .o_ch_level(lvl), .o_ch_fallback(fb));
   pfsof_loop_rdr u_pfsof_loop_rdr (.i_clk(i_clk), .i_level(lvl[0]),
      .i_otype(otype[0]), .o_alarm(rdr_alarm));
   // Sticky restart flag, set wins over acknowledge
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) exp24 <= 1'b0;
      else if (i_ce) exp24 <= cond[24] | (exp24 & ~ack);
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] err_lvl(pfsof_pkg::pfsof_otype_e t);
      if (t == pfsof_pkg::PFSOF_OUT_0_20MA) return `PFSOF_LVL_0_20MA;
      if (t == pfsof_pkg::PFSOF_OUT_4_20MA) return `PFSOF_LVL_4_20MA;
      return `PFSOF_LVL_VOLT;
   endfunction
   function automatic logic [31:0] exp_act();
      return (cond & (`PFSOF_CRIT_MASK | `PFSOF_ERR_MASK | `PFSOF_STAT_MASK
              | 32'h00A0_0000)) | {7'h00, exp24, 24'h000000};
   endfunction
   task automatic chk(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %0h exp %0h", $time, what,
                  got, exp);
      end
   endtask
   task automatic check_all();
      logic [31:0] a;
      logic e, c, f;
      logic [1:0] w;
      a = exp_act();
      e = |(a & `PFSOF_ERR_MASK);
      c = |(a & `PFSOF_CRIT_MASK);
      w = (e | c) ? 2'h3 : |(a & `PFSOF_WARN_MASK) ? 2'h2
          : |(a & `PFSOF_STAT_MASK) ? 2'h1 : 2'h0;
      chk(act, a, "active");
      chk({31'h0, err}, {31'h0, e}, "error");
      chk({31'h0, crit}, {31'h0, c}, "critical");
      chk({30'h0, worst}, {30'h0, w}, "worst");
      chk({16'h0, o_m}, e ? 32'h0 : {16'h0, meas}, "meas");
      chk({31'h0, o_mv}, {31'h0, meas_vld & ~e}, "meas vld");
      for (int i = 0; i < 2; i++) begin
         f = e | (ch_val[i] < ch_lo[i]) | (ch_val[i] > ch_hi[i]);
         chk({31'h0, fb[i]}, {31'h0, f}, "fallback");
         chk({16'h0, lvl[i]}, {16'h0, f ? err_lvl(otype[i]) : ch_val[i]},
             "level");
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge i_clk);
      #1 check_all();
   endtask
   task automatic wrap_up();
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000 err_count++;
      wrap_up();
   end
   initial begin
      for (int i = 0; i < 2; i++) begin
         otype[i] = pfsof_pkg::PFSOF_OUT_0_20MA;
         ch_lo[i] = 16'h0064;
         ch_hi[i] = 16'h00C8;
         ch_val[i] = 16'h0064 + 16'(i * 101);
      end
      repeat (10) @(posedge i_clk);
      i_rstn <= 1;
      // Low range edge inclusive, one above the high edge, every output type
      for (int t = 0; t < 4; t++) begin
         @(posedge i_clk);
         otype[0] <= pfsof_pkg::pfsof_otype_e'(t);
         otype[1] <= pfsof_pkg::pfsof_otype_e'(3 - t);
         settle();
      end
      // Error latency at the ports and at the loop meter
      @(posedge i_clk);
      otype[0] <= pfsof_pkg::PFSOF_OUT_4_20MA;
      ch_val[1] <= 16'h0096;
      cond <= 32'h0000_0200;
      @(posedge i_clk);
      #1 chk({31'h0, fb[0]}, 32'h0, "early fallback");
      @(posedge i_clk);
      #1 chk(act & 32'h200, 32'h200, "code 9");
      @(posedge i_clk);
      #1 chk({31'h0, fb[0]}, 32'h1, "fallback");
      @(posedge i_clk);
      #1 chk({31'h0, rdr_alarm}, 32'h1, "meter alarm");
      @(posedge i_clk);
      cond <= 32'h0;
      settle();
      // Clock enable low freezes the flags
      a0 = exp_act();
      @(posedge i_clk);
      i_ce <= 0;
      cond <= `PFSOF_CRIT_MASK | `PFSOF_ERR_MASK;
      repeat (3) @(posedge i_clk);
      #1 chk(act, a0, "frozen");
      @(posedge i_clk);
      i_ce <= 1;
      settle();
      // Lone cut warning keeps the result flowing
      @(posedge i_clk);
      cond <= 32'h0080_0000;
      meas_vld <= 1;
      meas <= 16'h1234;
      settle();
      // Restart warning sticks without ack, set beats ack
      @(posedge i_clk);
      cond <= 32'h4920_0000;
      settle();
      @(posedge i_clk);
      cond <= 32'h0;
      settle();
      chk(act & 32'h0100_0000, 32'h0100_0000, "restart kept");
      @(posedge i_clk);
      cond <= 32'h0100_0000;
      ack <= 1;
      settle();
      chk(act & 32'h0100_0000, 32'h0100_0000, "restart set wins");
      @(posedge i_clk);
      cond <= 32'h0;
      settle();
      chk(act & 32'h0100_0000, 32'h0, "restart cleared");
      for (int i = 0; i < 200; i++) begin
         @(posedge i_clk);
         r = $random(seed) & $random(seed) & $random(seed);
         cond <= i[0] ? (r & ~`PFSOF_ERR_MASK) : r;
         r = $random(seed);
         ack <= r[0];
         meas_vld <= r[1];
         meas <= r[31:16];
         for (int c = 0; c < 2; c++) begin
            r = $random(seed);
            otype[c] <= pfsof_pkg::pfsof_otype_e'(r[31:30]);
            ch_lo[c] <= {2'b00, r[13:0]};
            ch_hi[c] <= {2'b00, r[13:0]} + 16'h4000;
            ch_val[c] <= {1'b0, r[29:15]};
         end
         settle();
      end
      // Reset in mid-run clears flags and parks channels at fallback
      @(posedge i_clk);
      i_rstn <= 0;
      @(posedge i_clk);
      #1 chk(act, 32'h0, "reset active");
      chk({31'h0, fb[1]}, 32'h1, "reset fallback");
      // Release again and let the random inputs settle
      @(posedge i_clk);
      i_rstn <= 1;
      settle();
      wrap_up();
   end
endmodule
